//--- shared/pba_pkg.sv
package pba_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [15:0] OFS_MAP   = 16'hd100;
   localparam logic [15:0] OFS_CFG   = 16'hd104;
   localparam logic [15:0] OFS_STAT  = 16'hd108;
   localparam logic [15:0] OFS_MASK  = 16'hd10c;
   localparam logic [15:0] OFS_FLAGS = 16'hd110;
   localparam logic [15:0] OFS_REQV  = 16'hd114;
   localparam logic [15:0] OFS_GNTV  = 16'hd118;
   localparam logic [15:0] OFS_STV   = 16'hd11c;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int CFG_FIXED_BIT = 3;
   localparam int CFG_SRST_BIT  = 2;
   localparam int CFG_EN_BIT    = 1;
   localparam int CFG_CHK_BIT   = 0;
   localparam logic [3:0]  CFG_RESET  = 4'h0;
   localparam logic [31:0] MAP_RESET  = 32'h76543210;
   localparam logic [31:0] MAP_WMASK  = 32'h77777777;
   localparam logic [7:0]  GNT_RESET  = 8'h80;
   localparam logic [7:0]  FLAG_RESET = 8'h00;
   localparam logic [5:0]  SYNC_RESET = 6'h1f;
   localparam logic [2:0]  CODE_CTRL  = 3'h7;
   localparam int NPORT = 8;
   localparam int NEXT  = 4;
   localparam int FLD_W = 4;

   // ------------------------------------------------------------
   // timing: pci clocks a granted master may stay idle
   // ------------------------------------------------------------
   localparam int TMR_W = 4;
   localparam int BROKEN_PCI_CYCLES = 16;
   localparam logic [TMR_W-1:0] BROKEN_LAST =
      TMR_W'(BROKEN_PCI_CYCLES - 1);

   // ------------------------------------------------------------
   // carriers and states
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pba_bus_req_t;

   typedef enum logic [1:0] {
      ST_PARK,
      ST_GRANT,
      ST_BUSY
   } pba_arb_state_t;

endpackage

//--- logic/pba_arbiter.sv
`timescale 1ns/100ps

//Contract
// - fixed park 0 parks on last owner, 1 parks on port A
// - soft reset bit holds state machine in reset, config kept
// - external requests ignored until enable bit set; enable resets 0
// - after reset the bus parks on the internal controller
// - broken master checking only while check enable is 1
// - broken master sets its port bit, A at bit 7 to Z at 0
// - status flag set while any port flag set; write one clears
// - interrupt only when broken master interrupt enable is 1
// - a set port flag excludes that master from arbitration
// - request view: bit 7 controller, bits 3:0 external, reset 0
// - grant view: bit 7 controller, bits 3:0 external, reset 80
// - 13-bit read-only view of arbiter state, reset zero
// - registers act only while the on-chip arbiter is selected
// - 3-bit code per port: 111 controller, 000-011 external line
module pba_arbiter
   import pba_pkg::*;
(
   input  wire  logic              clk,
   input  wire  logic              resetn,
   input  wire  logic              onchip_arb_sel,
   input  wire  pba_pkg::pba_bus_req_t bus_req,
   output logic [31:0]             rdata,
   input  wire  logic              pci_clk,
   input  wire  logic              ctrl_req,
   output logic                    ctrl_gnt,
   input  wire  logic [3:0]        ext_req_n,
   output logic [3:0]              ext_gnt_n,
   input  wire  logic              frame_n,
   output logic                    irq
);
   import pba_pkg::*;

   // ------------------------------------------------------------
   // reset release and pin synchronisers
   // ------------------------------------------------------------
   logic       rst_s1;
   logic       rst_n;
   logic [5:0] sy1;
   logic [5:0] sy2;
   logic       pclk_d;

   // release through two stages, assertion stays asynchronous
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // pci clock, frame and request pins; first stage feeds sy2 only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1    <= SYNC_RESET;
         sy2    <= SYNC_RESET;
         pclk_d <= 1'b0;
      end else begin
         sy1    <= {pci_clk, frame_n, ext_req_n};
         sy2    <= sy1;
         pclk_d <= sy2[5];
      end
   end

   wire             pe       = sy2[5] & ~pclk_d;  // pci rising edge
   wire             frame_s  = ~sy2[4];           // frame asserted
   wire [NEXT-1:0]  ext_req  = ~sy2[3:0];
   wire             arb_on   = onchip_arb_sel;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [31:0]      map_reg;
   logic [3:0]       cfg_reg;
   logic             status_reg;
   logic             mask_reg;
   logic [7:0]       flags_reg;
   logic [31:0]      rdata_reg;
   logic             irq_reg;
   logic             ctrl_gnt_reg;
   logic [NEXT-1:0]  ext_gnt_n_reg;
   pba_arb_state_t   st_reg;
   pba_arb_state_t   st_next;
   logic [2:0]       owner_reg;
   logic [2:0]       owner_next;
   logic [TMR_W-1:0] timer_reg;
   logic [TMR_W-1:0] timer_next;
   logic [7:0]       bm_set;

   wire fixed_park = cfg_reg[CFG_FIXED_BIT];
   wire soft_rst   = cfg_reg[CFG_SRST_BIT];
   wire arb_en     = cfg_reg[CFG_EN_BIT];
   wire chk_en     = cfg_reg[CFG_CHK_BIT];

   // ------------------------------------------------------------
   // address decode; writes ignored when the arbiter is off-chip
   // ------------------------------------------------------------
   wire hit_map   = bus_req.addr == OFS_MAP;
   wire hit_cfg   = bus_req.addr == OFS_CFG;
   wire hit_stat  = bus_req.addr == OFS_STAT;
   wire hit_mask  = bus_req.addr == OFS_MASK;
   wire hit_flags = bus_req.addr == OFS_FLAGS;
   wire hit_reqv  = bus_req.addr == OFS_REQV;
   wire hit_gntv  = bus_req.addr == OFS_GNTV;
   wire hit_stv   = bus_req.addr == OFS_STV;
   wire wr_ok     = bus_req.wr & arb_on;
   wire wr_map    = wr_ok & hit_map;
   wire wr_cfg    = wr_ok & hit_cfg;
   wire wr_stat   = wr_ok & hit_stat;
   wire wr_mask   = wr_ok & hit_mask;
   wire wr_flags  = wr_ok & hit_flags;

   // ------------------------------------------------------------
   // port mapping, requests and exclusion
   // ------------------------------------------------------------
   logic [2:0]       pcode [NPORT];
   logic [NPORT-1:0] preq;
   logic [NPORT-1:0] pexcl;

   // port p uses field 7-p, so port A sits in the top nibble
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      assign pcode[p] = map_reg[(NPORT-1-p)*FLD_W +: 3];
      // external lines pass only once enabled
      assign preq[p]  = (pcode[p] == CODE_CTRL) ? ctrl_req :
                        !pcode[p][2] ? (ext_req[pcode[p][1:0]] &
                                        arb_en) : 1'b0;
      assign pexcl[p] = flags_reg[NPORT-1-p];
   end

   wire [NPORT-1:0] elig = preq & ~pexcl;

   // one-hot source grant for a code; reserved codes grant none
   function automatic logic [7:0] src_onehot(input logic [2:0] c);
      logic [7:0] r;
      r = 8'h00;
      if (c == CODE_CTRL) begin
         r = 8'h80;
      end else if (!c[2]) begin
         r[c[1:0]] = 1'b1;
      end
      return r;
   endfunction

   // nearest eligible port after the last owner wins
   function automatic logic [3:0] pick(input logic [7:0] e,
                                       input logic [2:0] last);
      logic [2:0] j;
      logic [3:0] r;
      r = 4'h0;
      for (int i = NPORT-1; i >= 0; i--) begin
         j = 3'(last + 3'(i) + 3'd1);
         if (e[j]) begin
            r = {1'b1, j};
         end
      end
      return r;
   endfunction

   wire [3:0] win       = pick(elig, owner_reg);
   wire       win_found = win[3];
   wire [2:0] win_idx   = win[2:0];
   // park on the last owner or on port A
   wire [2:0] park_port = fixed_park ? 3'h0 : owner_reg;
   wire       hold      = soft_rst | ~arb_on;

   // ------------------------------------------------------------
   // arbiter state machine, stepped on pci clock edges
   // ------------------------------------------------------------
   always_comb begin
      st_next    = st_reg;
      owner_next = owner_reg;
      timer_next = timer_reg;
      bm_set     = 8'h00;
      if (hold) begin
         st_next    = ST_PARK;
         owner_next = 3'h0;
         timer_next = '0;
      end else if (pe) begin
         unique case (st_reg)
            ST_PARK: begin
               if (win_found) begin
                  st_next    = ST_GRANT;
                  owner_next = win_idx;
                  timer_next = '0;
               end
            end
            ST_GRANT: begin
               if (frame_s) begin
                  st_next = ST_BUSY;
               end else if (!elig[owner_reg]) begin
                  st_next = ST_PARK;
               end else if (chk_en &&
                            timer_reg == BROKEN_LAST) begin
                  bm_set[~owner_reg] = 1'b1;
                  st_next = ST_PARK;
               end else begin
                  timer_next = timer_reg + 1'b1;
               end
            end
            ST_BUSY: begin
               // re-arbitrate once the owner ends its frame
               if (!frame_s) begin
                  st_next = ST_PARK;
               end
            end
            default: begin
               st_next = ST_PARK;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg    <= ST_PARK;
         owner_reg <= 3'h0;
         timer_reg <= '0;
      end else begin
         st_reg    <= st_next;
         owner_reg <= owner_next;
         timer_reg <= timer_next;
      end
   end

   // ------------------------------------------------------------
   // grant selection; an excluded park port gets no idle grant
   // ------------------------------------------------------------
   wire [7:0] park_gnt = pexcl[park_port] ? 8'h00 :
                         src_onehot(pcode[park_port]);
   wire [7:0] own_gnt  = src_onehot(pcode[owner_reg]);
   // one owner at a time, parking only in the park state
   wire [7:0] gnt_next = !arb_on ? 8'h00 :
                         (st_reg == ST_PARK) ? park_gnt : own_gnt;

   // grants registered so pins come straight from flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_gnt_reg  <= GNT_RESET[7];
         ext_gnt_n_reg <= ~GNT_RESET[3:0];
      end else begin
         ctrl_gnt_reg  <= gnt_next[7];
         ext_gnt_n_reg <= ~gnt_next[3:0];
      end
   end

   // ------------------------------------------------------------
   // configuration, mapping and mask; soft reset keeps them
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         map_reg  <= MAP_RESET;
         cfg_reg  <= CFG_RESET;
         mask_reg <= 1'b0;
      end else begin
         if (wr_map) begin
            map_reg <= bus_req.wdata & MAP_WMASK;
         end
         // the soft reset bit clears only through a software write or the hardware reset here
         if (wr_cfg) begin
            cfg_reg <= bus_req.wdata[3:0];
         end
         if (wr_mask) begin
            mask_reg <= bus_req.wdata[0];
         end
      end
   end

   // ------------------------------------------------------------
   // port flags, sticky status and interrupt
   // ------------------------------------------------------------
   // hardware sets win over a same-cycle software write
   wire [7:0] flags_next = (wr_flags ? bus_req.wdata[7:0] :
                            flags_reg) | bm_set;
   wire       stat_clr   = wr_stat & bus_req.wdata[0];
   // level set from any flag beats the write-one clear
   wire       stat_next  = (|flags_reg) | (status_reg & ~stat_clr);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg  <= FLAG_RESET;
         status_reg <= 1'b0;
         irq_reg    <= 1'b0;
      end else begin
         flags_reg  <= flags_next;
         status_reg <= stat_next;
         irq_reg    <= status_reg & mask_reg;
      end
   end

   // ------------------------------------------------------------
   // read side: diagnostic views and the data mux
   // ------------------------------------------------------------
   wire [7:0]  live_request_bits = {ctrl_req, 3'h0, ext_req};
   wire [7:0]  live_grant_bits   = {ctrl_gnt_reg, 3'h0,
                                    ~ext_gnt_n_reg};
   wire [12:0] arbiter_state_bits = {4'h0, st_reg, owner_reg,
                                     timer_reg};
   // views read zero while an external arbiter is used
   wire [31:0] rd_mux =
      {32{arb_on}} & (
      ({32{hit_map}}   & map_reg) |
      ({32{hit_cfg}}   & {28'h0, cfg_reg}) |
      ({32{hit_stat}}  & {31'h0, status_reg}) |
      ({32{hit_mask}}  & {31'h0, mask_reg}) |
      ({32{hit_flags}} & {24'h0, flags_reg}) |
      ({32{hit_reqv}}  & {24'h0, live_request_bits}) |
      ({32{hit_gntv}}  & {24'h0, live_grant_bits}) |
      ({32{hit_stv}}   & {19'h0, arbiter_state_bits}));

   // data stand only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= bus_req.rd ? rd_mux : 32'h0;
      end
   end

   assign rdata     = rdata_reg;
   assign irq       = irq_reg;
   assign ctrl_gnt  = ctrl_gnt_reg;
   assign ext_gnt_n = ext_gnt_n_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_onehot;
      $onehot0({ctrl_gnt, ~ext_gnt_n});
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("more than one grant");

   property p_fixpark;
      (arb_on && st_reg == ST_PARK && fixed_park && !pexcl[0])
      |=> ({ctrl_gnt, 3'h0, ~ext_gnt_n} ==
           src_onehot($past(pcode[0])));
   endproperty
   a_fixpark: assert property (p_fixpark)
      else $error("fixed park not on port a");

   property p_srst;
      soft_rst |=> (st_reg == ST_PARK && timer_reg == '0 &&
                    owner_reg == 3'h0);
   endproperty
   a_srst: assert property (p_srst)
      else $error("arbiter ran during soft reset");

   property p_srst_keep;
      (soft_rst && !wr_map && !wr_mask) |=>
         ($stable(map_reg) && $stable(mask_reg));
   endproperty
   a_srst_keep: assert property (p_srst_keep)
      else $error("config lost in soft reset");

   property p_noext;
      (pe && !hold && st_reg == ST_PARK && !arb_en) |=>
         (st_reg != ST_GRANT || pcode[owner_reg] == CODE_CTRL ||
          $changed(map_reg));
   endproperty
   a_noext: assert property (p_noext)
      else $error("external master won while disabled");

   property p_chk_off;
      (!chk_en && !wr_flags) |=> $stable(flags_reg);
   endproperty
   a_chk_off: assert property (p_chk_off)
      else $error("port flag set with checking off");

   property p_broken;
      (pe && !hold && st_reg == ST_GRANT && chk_en && !frame_s &&
       elig[owner_reg] && timer_reg == BROKEN_LAST)
      |=> (flags_reg[~$past(owner_reg)] && st_reg == ST_PARK)
          ##1 status_reg;
   endproperty
   a_broken: assert property (p_broken)
      else $error("broken master not flagged");

   property p_status;
      (|flags_reg) |=> status_reg;
   endproperty
   a_status: assert property (p_status)
      else $error("status clear while a flag is set");

   property p_irq;
      (status_reg && mask_reg) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("masked-in status gave no interrupt");

   property p_irq_off;
      !mask_reg |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt while disabled");

   property p_excl;
      (st_reg == ST_PARK && st_next == ST_GRANT) |->
         !flags_reg[~win_idx];
   endproperty
   a_excl: assert property (p_excl)
      else $error("excluded master was granted");

   property p_reqv;
      (bus_req.rd && hit_reqv && arb_on) |=>
         rdata == {24'h0, $past(live_request_bits)};
   endproperty
   a_reqv: assert property (p_reqv)
      else $error("request view mismatch");

   property p_offchip;
      !arb_on |=> (!ctrl_gnt && ext_gnt_n == 4'hf);
   endproperty
   a_offchip: assert property (p_offchip)
      else $error("grant while arbiter is off-chip");

endmodule

//--- sim/pba_pci_masters.sv
`timescale 1ns/100ps

// ----------------------------------------------------------
// four external pci masters and their free-running clock
// ----------------------------------------------------------
module pba_pci_masters (
   input  wire logic [3:0] want,
   input  wire logic [3:0] stuck,
   input  wire logic [3:0] ext_gnt_n,
   output logic            pci_clk,
   output logic [3:0]      ext_req_n,
   output logic            frame_n
);
   logic [1:0] len_reg;

   // odd offset keeps the link clock unrelated in phase to clk
   initial begin
      pci_clk = 1'b0;
      #3.7;
      forever #40 pci_clk = ~pci_clk;
   end

   // pulled-up lines idle high
   initial begin
      ext_req_n = 4'hf;
      frame_n   = 1'b1;
      len_reg   = 2'h0;
   end

   // a granted master starts a three-cycle burst on an idle bus and
   // drops its request with it; a stuck master never drives frame
   always @(posedge pci_clk) begin
      ext_req_n <= ~want;
      if (!frame_n) begin
         len_reg <= len_reg - 2'h1;
         if (len_reg == 2'h0) frame_n <= 1'b1;
      end
      for (int i = 0; i < 4; i++) begin
         if (frame_n && !ext_gnt_n[i] && !ext_req_n[i] && !stuck[i]) begin
            frame_n      <= 1'b0;
            len_reg      <= 2'h2;
            ext_req_n[i] <= 1'b1;
         end
      end
   end
endmodule

//--- sim/pci_bus_arbiter_control_test.sv
`timescale 1ns/100ps

module pci_bus_arbiter_control_test;
   import pba_pkg::*;

   logic                  clk;
   logic                  resetn;
   logic                  onchip_arb_sel;
   pba_pkg::pba_bus_req_t bus_req;
   logic [31:0]           rdata;
   logic                  pci_clk;
   logic                  ctrl_req;
   logic                  ctrl_gnt;
   logic [3:0]            ext_req_n;
   logic [3:0]            ext_gnt_n;
   logic                  frame_n;
   logic                  irq;
   logic [3:0]            want;
   logic [3:0]            stuck;
   logic [3:0]            w;
   logic [4:0]            seen;
   logic [31:0]           q;
   logic                  rst_done;
   int                    errors;
   int                    checks_done;
   wire  logic [4:0]      gv = {ctrl_gnt, ~ext_gnt_n};

   logic [15:0] tbl_a[9] = '{OFS_MAP, OFS_CFG, OFS_STAT, OFS_MASK,
      OFS_FLAGS, OFS_REQV, OFS_GNTV, OFS_STV, 16'hd120};
   logic [31:0] tbl_e[9] = '{MAP_RESET, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0, {24'h0, GNT_RESET}, 32'h0, 32'h0};

   pba_arbiter DUT (.clk(clk), .resetn(resetn),
      .onchip_arb_sel(onchip_arb_sel), .bus_req(bus_req), .rdata(rdata),
      .pci_clk(pci_clk), .ctrl_req(ctrl_req), .ctrl_gnt(ctrl_gnt),
      .ext_req_n(ext_req_n), .ext_gnt_n(ext_gnt_n), .frame_n(frame_n),
      .irq(irq));

   pba_pci_masters masters (.want(want), .stuck(stuck),
      .ext_gnt_n(ext_gnt_n), .pci_clk(pci_clk), .ext_req_n(ext_req_n),
      .frame_n(frame_n));

   always #5 clk = ~clk;

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus_req <= '0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      bus_req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      bus_req <= '0;
      #1 q = rdata;
   endtask

   task automatic rchk(input logic [15:0] a, input logic [31:0] e);
      rd(a);
      check(q, e);
   endtask

   // synchronisers and the idle timer make these waits long
   task automatic poll(input logic [15:0] a, input logic [31:0] e);
      for (int n = 0; n < 200; n++) begin
         rd(a);
         if (q === e) break;
      end
      check(q, e);
   endtask

   task automatic wait_gv(input logic [4:0] e);
      for (int n = 0; n < 400; n++) begin
         @(posedge clk);
         #1;
         if (gv === e) break;
      end
      check({27'h0, gv}, {27'h0, e});
   endtask

   task automatic irq_after(input logic [15:0] a, input logic [31:0] d,
                            input logic e);
      wr(a, d);
      repeat (2) @(posedge clk);
      #1 check({31'h0, irq}, {31'h0, e});
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one-hot grant watch and record of every grant seen
   always @(posedge clk) begin
      if (rst_done) begin
         check({27'h0, gv & (gv - 5'd1)}, 32'h0);
         seen <= seen | gv;
      end
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      onchip_arb_sel = 1'b1;
      bus_req = '0;
      ctrl_req = 1'b0;
      want = 4'h0;
      stuck = 4'h0;
      seen = 5'h0;
      rst_done = 1'b0;
      errors = 0;
      checks_done = 0;
      void'($urandom(32'h8ccb3b94));
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rst_done <= 1'b1;
      // reset values, unmapped place, ignored grant-view write
      wr(OFS_GNTV, 32'h0);
      for (int i = 0; i < 9; i++) begin
         rchk(tbl_a[i], tbl_e[i]);
      end
      wait_gv(5'h10);
      // disabled arbiter: requests visible, external ones never served
      want <= 4'b0101;
      ctrl_req <= 1'b1;
      poll(OFS_REQV, 32'h85);
      seen = 5'h0;
      repeat (150) @(posedge clk);
      check({28'h0, seen[3:0]}, 32'h0);
      ctrl_req <= 1'b0;
      want <= 4'h0;
      wr(OFS_CFG, 32'h2);
      // random request sets: every requester is served in turn
      for (int r = 0; r < 8; r++) begin
         w = 4'($urandom_range(15, 1));
         want <= w;
         // clear off the edge so the watcher's update cannot undo it
         #1 seen = 5'h0;
         for (int n = 0; n < 3000 && (seen[3:0] & w) != w; n++)
            @(posedge clk);
         check({28'h0, seen[3:0] & w}, {28'h0, w});
         want <= 4'h0;
         repeat (80) @(posedge clk);
      end
      // parking on last owner, then on port A
      want <= 4'b0010;
      wait_gv(5'h02);
      want <= 4'h0;
      repeat (100) @(posedge clk);
      wait_gv(5'h02);
      rchk(OFS_GNTV, 32'h02);
      wr(OFS_CFG, 32'ha);
      wait_gv(5'h10);
      // soft reset: config kept, machine back to park on A
      wr(OFS_CFG, 32'h6);
      rchk(OFS_CFG, 32'h6);
      rchk(OFS_STV, 32'h0);
      wait_gv(5'h10);
      wr(OFS_CFG, 32'h2);
      // a flagged port is excluded even with checking off
      wr(OFS_FLAGS, 32'h01);
      want <= 4'b0001;
      #1 seen = 5'h0;
      repeat (300) @(posedge clk);
      check({31'h0, seen[0]}, 32'h0);
      poll(OFS_STAT, 32'h1);
      check({31'h0, irq}, 32'h0);
      want <= 4'h0;
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_STAT, 32'h1);
      rchk(OFS_STAT, 32'h0);
      // stuck master with checking off is never flagged
      stuck <= 4'b0010;
      want <= 4'b0010;
      repeat (400) @(posedge clk);
      rchk(OFS_FLAGS, 32'h0);
      // held grant on port y: state grant, owner 6, timer running
      rd(OFS_STV);
      check({23'h0, q[12:4]}, {23'h0, 9'h00e});
      want <= 4'h0;
      stuck <= 4'h0;
      repeat (80) @(posedge clk);
      // stuck master with checking on: flag, status, masked interrupt
      wr(OFS_CFG, 32'h3);
      stuck <= 4'b1000;
      want <= 4'b1000;
      poll(OFS_FLAGS, 32'h08);
      poll(OFS_STAT, 32'h1);
      check({31'h0, irq}, 32'h0);
      irq_after(OFS_MASK, 32'h1, 1'b1);
      irq_after(OFS_MASK, 32'h0, 1'b0);
      want <= 4'h0;
      stuck <= 4'h0;
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_STAT, 32'h1);
      rchk(OFS_STAT, 32'h0);
      // remap port A to external line 0, distinct codes kept
      wr(OFS_MAP, 32'h86543217);
      rchk(OFS_MAP, 32'h06543217);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_CFG, 32'ha);
      wait_gv(5'h01);
      wr(OFS_MAP, MAP_RESET);
      wr(OFS_FLAGS, 32'h0);
      // external arbiter in use: grants off, registers inert
      onchip_arb_sel <= 1'b0;
      wait_gv(5'h00);
      rchk(OFS_CFG, 32'h0);
      wr(OFS_CFG, 32'h0);
      onchip_arb_sel <= 1'b1;
      rchk(OFS_CFG, 32'ha);
      print_verdict();
   end
endmodule
